// >>> testbench/pgr_gain_regs_bench.sv
// Testbench: register accesses and gain codes of the gain register group
`timescale 1ns/1ps
module pgr_gain_regs_bench;
   import pgr_pkg::*;
   logic        i_clk = 0, i_reset = 1, i_ce = 1, i_wr = 0, i_rd = 0, tw = 0, tr = 0, lo[3];
   logic [5:0]  i_addr = 6'h00;
   logic [7:0]  i_wdata = 8'h00, o_rdata, hi[3], d, qr[$];
   logic [8:0]  o_red_gain_code, o_green_gain_code, o_blue_gain_code;
   logic [26:0] qc[$];
   int          err_total = 0, num_checks = 0, seed = 94, cyc = 0;
   pgr_gain_regs pgr_gain_regs_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_red_gain_code(o_red_gain_code), .o_green_gain_code(o_green_gain_code),
      .o_blue_gain_code(o_blue_gain_code));
   initial forever #12.5 i_clk = ~i_clk;
   // ****************
   // Bus tasks, model
   // ****************
   task complete_run;
      if (err_total == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   task chk8(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin err_total++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end
   endtask : chk8
   task chk27(input logic [26:0] g, input logic [26:0] e);
      num_checks++;
      if (g !== e) begin err_total++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end
   endtask : chk27
   task wr(input logic [5:0] a, input logic [7:0] v);
      @(posedge i_clk); i_addr <= a; i_wdata <= v; i_wr <= 1'b1; i_rd <= 1'b0;
      if (i_ce) begin
         case (a)
            ADDR_RED_LOW, ADDR_GREEN_LOW, ADDR_BLUE_LOW: lo[a - ADDR_RED_LOW] = v[0];
            ADDR_ALL_LOW: lo = '{v[0], v[0], v[0]};
            ADDR_RED_HIGH, ADDR_GREEN_HIGH, ADDR_BLUE_HIGH: hi[a - ADDR_RED_HIGH] = v;
            ADDR_ALL_HIGH: hi = '{v, v, v};
            default: ;
         endcase
         qc.push_back({hi[0], lo[0], hi[1], lo[1], hi[2], lo[2]});
      end
   endtask : wr
   task rd(input logic [5:0] a);
      @(posedge i_clk); i_addr <= a; i_rd <= 1'b1; i_wr <= 1'b0;
      if (a >= ADDR_RED_LOW && a <= ADDR_BLUE_LOW) qr.push_back({7'h00, lo[a - ADDR_RED_LOW]});
      else if (a >= ADDR_RED_HIGH && a <= ADDR_BLUE_HIGH) qr.push_back(hi[a - ADDR_RED_HIGH]);
      else qr.push_back(8'h00);
   endtask : rd
   task ce_set(input logic v);
      @(posedge i_clk); i_ce <= v; i_wr <= 1'b0; i_rd <= 1'b0;
   endtask : ce_set
   // ****************
   // Watcher
   // ****************
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      tw <= i_wr & i_ce & !i_reset;
      tr <= i_rd & i_ce & !i_reset;
      if (cyc > 2000) begin err_total++; complete_run; end
   end
   always @(negedge i_clk) begin
      if (tw) chk27({o_red_gain_code, o_green_gain_code, o_blue_gain_code}, qc.pop_front());
      if (tr) chk8(o_rdata, qr.pop_front());
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      hi = '{RESET_HIGH, RESET_HIGH, RESET_HIGH}; lo = '{1'b0, 1'b0, 1'b0};
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      for (int a = 'h20; a < 'h30; a++) rd(a[5:0]);
      repeat (6) begin
         for (int a = 'h23; a < 'h2D; a++) begin
            d = 8'($random(seed));
            wr(a[5:0], (a < 'h28) ? (d & 8'h01) : d);
         end
         for (int a = 'h23; a < 'h2D; a++) rd(a[5:0]);
      end
      ce_set(1'b0); wr(ADDR_ALL_HIGH, 8'hA5); ce_set(1'b1); rd(ADDR_RED_HIGH);
      ce_set(1'b1); repeat (3) @(posedge i_clk);
      complete_run;
   end
endmodule : pgr_gain_regs_bench

// >>> verilog/pgr_gain_regs.sv
// Module: gain code register group for red, green and blue channels
`timescale 1ns/1ps
// How it works
// - Broadcast low-bit write sets red, green and blue low bits together.
// - Red high register holds code bits 8..1, resets to 00001100.
// - Green high register holds code bits 8..1, resets to 00001100.
// - Blue high register holds code bits 8..1, resets to 00001100.
// - Broadcast high-bits write sets all three high bytes together.
// - Bit 0 of each low register is the code's least significant bit.
module pgr_gain_regs (
   input  wire logic                       i_clk,
   input  wire logic                       i_reset,
   input  wire logic                       i_ce,
   input  wire logic [pgr_pkg::ADDR_W-1:0] i_addr,
   input  wire logic [pgr_pkg::DATA_W-1:0] i_wdata,
   input  wire logic                       i_wr,
   input  wire logic                       i_rd,
   output logic      [pgr_pkg::DATA_W-1:0] o_rdata,
   output logic      [pgr_pkg::CODE_W-1:0] o_red_gain_code,
   output logic      [pgr_pkg::CODE_W-1:0] o_green_gain_code,
   output logic      [pgr_pkg::CODE_W-1:0] o_blue_gain_code
);
   import pgr_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0][7:0] high;
      logic [2:0]      low;
      logic [7:0]      rdata;
   } pgr_state_t;

   pgr_state_t st;
   pgr_state_t next_st;

   // Channel index 0 red, 1 green, 2 blue
   function automatic logic hit(input logic [5:0] a, input logic [5:0] ch, input logic [5:0] all);
      hit = (a == ch) || (a == all);
   endfunction : hit

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_st = st;
      if (i_wr) begin
         for (int c = 0; c < 3; c++) begin
            // Broadcast and own location share one path, so all three update in one cycle
            if (hit(i_addr, ADDR_RED_LOW + 6'(c), ADDR_ALL_LOW)) begin
               next_st.low[c] = i_wdata[LOW_BIT_POS];
            end
            if (hit(i_addr, ADDR_RED_HIGH + 6'(c), ADDR_ALL_HIGH)) begin
               next_st.high[c] = i_wdata;
            end
         end
      end
      next_st.rdata = 8'h00;
      if (i_rd) begin
         // Broadcast locations are write-only and read as zero; reserved bits read zero
         unique case (i_addr)
            ADDR_RED_LOW:    next_st.rdata = {7'h00, st.low[0]};
            ADDR_GREEN_LOW:  next_st.rdata = {7'h00, st.low[1]};
            ADDR_BLUE_LOW:   next_st.rdata = {7'h00, st.low[2]};
            ADDR_RED_HIGH:   next_st.rdata = st.high[0];
            ADDR_GREEN_HIGH: next_st.rdata = st.high[1];
            ADDR_BLUE_HIGH:  next_st.rdata = st.high[2];
            default:         next_st.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st.high  <= {RESET_HIGH, RESET_HIGH, RESET_HIGH};
         st.low   <= {3{RESET_LOW}};
         st.rdata <= 8'h00;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_rdata           = st.rdata;
   // Every channel forms its code the same way, so one loop builds all three
   logic [CODE_W-1:0] chan_code [3];
   for (genvar g = 0; g < 3; g++) begin : g_code
      assign chan_code[g] = {st.high[g], st.low[g]};
   end
   assign o_red_gain_code   = chan_code[0];
   assign o_green_gain_code = chan_code[1];
   assign o_blue_gain_code  = chan_code[2];

   // ************************************************************
   // Assertions
   // ************************************************************
   a_low_broadcast: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_ALL_LOW) |=> (o_red_gain_code[0] == $past(i_wdata[0])
      && o_green_gain_code[0] == $past(i_wdata[0]) && o_blue_gain_code[0] == $past(i_wdata[0])))
      else $error("broadcast low bit not applied");
   a_red_reset: assert property (@(posedge i_clk) i_reset |=> o_red_gain_code[8:1] == 8'h0C)
      else $error("red high reset wrong");
   a_green_reset: assert property (@(posedge i_clk) i_reset |=> o_green_gain_code[8:1] == 8'h0C)
      else $error("green high reset wrong");
   a_blue_reset: assert property (@(posedge i_clk) i_reset |=> o_blue_gain_code[8:1] == 8'h0C)
      else $error("blue high reset wrong");
   a_high_broadcast: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_ALL_HIGH) |=> (o_red_gain_code[8:1] == $past(i_wdata)
      && o_green_gain_code[8:1] == $past(i_wdata) && o_blue_gain_code[8:1] == $past(i_wdata)))
      else $error("broadcast high bits not applied");
   a_green_own: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_GREEN_HIGH) |=> (o_green_gain_code[8:1] == $past(i_wdata)
      && $stable(o_red_gain_code) && $stable(o_blue_gain_code)))
      else $error("green high write wrong");
   a_blue_low_bit: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_BLUE_LOW) |=> (o_blue_gain_code[0] == $past(i_wdata[0])
      && $stable(o_blue_gain_code[8:1])))
      else $error("blue low bit write wrong");
   a_red_readback: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_RED_HIGH) |=> o_rdata == $past(o_red_gain_code[8:1]))
      else $error("red high readback wrong");
   a_freeze: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_ce |=> ($stable(o_red_gain_code) && $stable(o_rdata)))
      else $error("state moved while clock enable low");

   // ************************************************************
   // Assertions: reset of low bits, codes and read data
   // ************************************************************
   // Read port comes up quiet so a first read after reset sees no stale byte
   a_red_low_reset: assert property (@(posedge i_clk)
      i_reset |=> o_red_gain_code[LOW_BIT_POS] == RESET_LOW)
      else $error("red low bit reset wrong");

   a_green_low_reset: assert property (@(posedge i_clk)
      i_reset |=> o_green_gain_code[LOW_BIT_POS] == RESET_LOW)
      else $error("green low bit reset wrong");

   a_blue_low_reset: assert property (@(posedge i_clk)
      i_reset |=> o_blue_gain_code[LOW_BIT_POS] == RESET_LOW)
      else $error("blue low bit reset wrong");

   a_red_code_reset: assert property (@(posedge i_clk)
      i_reset |=> o_red_gain_code == {RESET_HIGH, RESET_LOW})
      else $error("red code reset wrong");

   a_green_code_reset: assert property (@(posedge i_clk)
      i_reset |=> o_green_gain_code == {RESET_HIGH, RESET_LOW})
      else $error("green code reset wrong");

   a_blue_code_reset: assert property (@(posedge i_clk)
      i_reset |=> o_blue_gain_code == {RESET_HIGH, RESET_LOW})
      else $error("blue code reset wrong");

   a_ce_low_reset: assert property (@(posedge i_clk)
      (i_reset && !i_ce) |=> o_red_gain_code[8:1] == RESET_HIGH)
      else $error("reset ignored while clock enable low");

   a_rdata_reset: assert property (@(posedge i_clk)
      i_reset |=> o_rdata == 8'h00)
      else $error("read data reset wrong");

   // ************************************************************
   // Assertions: per-channel high writes
   // ************************************************************
   // Own writes must not leak into the other channels
   a_red_own: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_RED_HIGH)
      |=> (o_red_gain_code[8:1] == $past(i_wdata)
      && $stable(o_green_gain_code) && $stable(o_blue_gain_code)))
      else $error("red high write wrong");

   a_blue_own: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_BLUE_HIGH)
      |=> (o_blue_gain_code[8:1] == $past(i_wdata)
      && $stable(o_red_gain_code) && $stable(o_green_gain_code)))
      else $error("blue high write wrong");

   a_red_high_keeps_low: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_RED_HIGH) |=> $stable(o_red_gain_code[0]))
      else $error("red low bit moved on high write");

   a_green_high_keeps_low: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_GREEN_HIGH) |=> $stable(o_green_gain_code[0]))
      else $error("green low bit moved on high write");

   a_blue_high_keeps_low: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_BLUE_HIGH) |=> $stable(o_blue_gain_code[0]))
      else $error("blue low bit moved on high write");

   // ************************************************************
   // Assertions: per-channel low writes
   // ************************************************************
   // Only bit 0 of the written byte counts; the reserved bits are dropped
   a_red_low_bit: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_RED_LOW)
      |=> (o_red_gain_code[0] == $past(i_wdata[0]) && $stable(o_red_gain_code[8:1])
      && $stable(o_green_gain_code) && $stable(o_blue_gain_code)))
      else $error("red low bit write wrong");

   a_green_low_bit: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_GREEN_LOW)
      |=> (o_green_gain_code[0] == $past(i_wdata[0]) && $stable(o_green_gain_code[8:1])
      && $stable(o_red_gain_code) && $stable(o_blue_gain_code)))
      else $error("green low bit write wrong");

   // ************************************************************
   // Assertions: broadcast writes
   // ************************************************************
   // A broadcast write touches one half of each code and must leave the other half
   a_low_keeps_high: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_ALL_LOW)
      |=> ($stable(o_red_gain_code[8:1]) && $stable(o_green_gain_code[8:1])
      && $stable(o_blue_gain_code[8:1])))
      else $error("broadcast low write moved high bits");

   a_high_keeps_low: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && i_addr == ADDR_ALL_HIGH)
      |=> ($stable(o_red_gain_code[0]) && $stable(o_green_gain_code[0])
      && $stable(o_blue_gain_code[0])))
      else $error("broadcast high write moved low bits");

   // ************************************************************
   // Assertions: read-back
   // ************************************************************
   // Read data stands only until the next edge with clock enable high, so it is checked on the very next edge
   a_green_readback: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_GREEN_HIGH)
      |=> o_rdata == $past(o_green_gain_code[8:1]))
      else $error("green high readback wrong");

   a_blue_readback: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_BLUE_HIGH)
      |=> o_rdata == $past(o_blue_gain_code[8:1]))
      else $error("blue high readback wrong");

   a_red_low_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_RED_LOW)
      |=> o_rdata == {7'h00, $past(o_red_gain_code[0])})
      else $error("red low bit readback wrong");

   a_green_low_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_GREEN_LOW)
      |=> o_rdata == {7'h00, $past(o_green_gain_code[0])})
      else $error("green low bit readback wrong");

   a_blue_low_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_BLUE_LOW)
      |=> o_rdata == {7'h00, $past(o_blue_gain_code[0])})
      else $error("blue low bit readback wrong");

   // ************************************************************
   // Assertions: write-only locations and idle port
   // ************************************************************
   // Broadcast locations are write-only, and a quiet port must read as zero
   a_all_low_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_ALL_LOW)
      |=> o_rdata == 8'h00)
      else $error("broadcast low location read not zero");

   a_all_high_read: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd && i_addr == ADDR_ALL_HIGH)
      |=> o_rdata == 8'h00)
      else $error("broadcast high location read not zero");

   a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && !i_rd) |=> o_rdata == 8'h00)
      else $error("read data not cleared");

   a_wr_no_rdata: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr) |=> o_rdata == 8'h00)
      else $error("write produced read data");

   // ************************************************************
   // Assertions: holding
   // ************************************************************
   // Gain codes are analogue settings, so a stray change would show up as a gain step
   a_hold_no_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && !i_wr)
      |=> ($stable(o_red_gain_code) && $stable(o_green_gain_code)
      && $stable(o_blue_gain_code)))
      else $error("gain code moved without a write");

   a_rd_keeps_codes: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_rd)
      |=> ($stable(o_red_gain_code) && $stable(o_green_gain_code)
      && $stable(o_blue_gain_code)))
      else $error("gain code moved on a read");

   a_unmapped_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_ce && i_wr && (i_addr < ADDR_RED_LOW || i_addr > ADDR_ALL_HIGH))
      |=> ($stable(o_red_gain_code) && $stable(o_green_gain_code)
      && $stable(o_blue_gain_code)))
      else $error("unmapped write moved a gain code");

   a_freeze_gb: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_ce |=> ($stable(o_green_gain_code) && $stable(o_blue_gain_code)))
      else $error("green or blue moved while clock enable low");
endmodule : pgr_gain_regs

// >>> verilog/pgr_pkg.sv
// Package: register map and reset values of the gain register group
package pgr_pkg;
   localparam int         ADDR_W          = 6;
   localparam int         DATA_W          = 8;
   localparam int         CODE_W          = 9;
   // Per-channel low-bit registers sit just below the broadcast location
   localparam logic [5:0] ADDR_RED_LOW    = 6'h24;
   localparam logic [5:0] ADDR_GREEN_LOW  = 6'h25;
   localparam logic [5:0] ADDR_BLUE_LOW   = 6'h26;
   localparam logic [5:0] ADDR_ALL_LOW    = 6'h27;
   localparam logic [5:0] ADDR_RED_HIGH   = 6'h28;
   localparam logic [5:0] ADDR_GREEN_HIGH = 6'h29;
   localparam logic [5:0] ADDR_BLUE_HIGH  = 6'h2A;
   localparam logic [5:0] ADDR_ALL_HIGH   = 6'h2B;
   localparam logic [7:0] RESET_HIGH      = 8'h0C;
   localparam logic       RESET_LOW       = 1'b0;
   localparam int         LOW_BIT_POS     = 0;
endpackage : pgr_pkg
